// file: design/pmfb_consts.vh
`ifndef PMFB_CONSTS_VH
`define PMFB_CONSTS_VH

// Host command codes, first byte of every link transaction
`define CMD_TX_WRITE    8'h01
`define CMD_TX_GO       8'h02
`define CMD_RX_READ     8'h03
`define CMD_STATUS      8'h04
`define CMD_ED_GO       8'h05

// Frame format
`define PRE_BYTES       4
`define PRE_BYTE        8'h00
`define SFD_BYTE        8'hA7
`define FCS_BYTES       2
`define MAX_PAYLOAD     125
`define CRC_POLY_REFL   16'h8408

// Status bit positions
`define ST_TX_DONE      0
`define ST_RX_DONE      1
`define ST_ED_DONE      2

// Timing
`define CLK_PERIOD_NS   4
`define LQI_TIME_NS     64000
`define ED_TIME_NS      128000

`endif

// file: design/crc16_unit.v
`timescale 1ns/1ps
`include "pmfb_consts.vh"

module crc16_unit (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Byte stream
  input  wire        clr,
  input  wire        en,
  input  wire [7:0]  data,
  // Running check value
  output reg  [15:0] crc
);

  reg [15:0] next_crc;
  reg        fb;
  integer    i;

  // Bitwise reflected update, least significant bit first
  always @* begin
    next_crc = crc;
    fb       = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      fb       = next_crc[0] ^ data[i];
      next_crc = {1'b0, next_crc[15:1]};
      if (fb) begin
        next_crc = next_crc ^ `CRC_POLY_REFL;
      end
    end
  end

  // Clear has priority over an update
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc <= 16'h0000;
    end else if (clr) begin
      crc <= 16'h0000;
    end else if (en) begin
      crc <= next_crc;
    end
  end

endmodule

// file: design/byte_fifo.v
`timescale 1ns/1ps

module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rstn,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  // Storage
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// file: design/packet_mode_frame_buffer.v
`timescale 1ns/1ps
`include "pmfb_consts.vh"

module packet_mode_frame_buffer #(
  parameter LQI_CYCLES = `LQI_TIME_NS / `CLK_PERIOD_NS,
  parameter ED_CYCLES  = `ED_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rstn,
  // Host serial link
  input  wire       spi_sclk,
  input  wire       spi_cs_n,
  input  wire       spi_mosi,
  output reg        spi_miso,
  output reg        spi_miso_oe,
  output reg        irq_n,
  // Modem transmit byte stream
  output reg  [7:0] sym_data,
  output reg        sym_valid,
  input  wire       sym_ready,
  // Modem receive byte stream and measurements
  input  wire [7:0] rx_data,
  input  wire       rx_valid,
  input  wire [7:0] rx_level,
  input  wire [7:0] bb_energy
);

  localparam [31:0] LQI_SPAN = LQI_CYCLES - 1;
  localparam [31:0] ED_SPAN  = ED_CYCLES - 1;
  localparam [15:0] LQI_LAST = LQI_SPAN[15:0];
  localparam [15:0] ED_LAST  = ED_SPAN[15:0];
  localparam [6:0]  MAX_PAY  = `MAX_PAYLOAD;
  localparam [6:0]  FCS_LEN  = `FCS_BYTES;
  localparam [2:0]  PRE_LAST = `PRE_BYTES - 1;
  localparam [2:0]  PRE_FULL = `PRE_BYTES;

  localparam [2:0] T_IDLE  = 3'd0;
  localparam [2:0] T_PRE   = 3'd1;
  localparam [2:0] T_SFD   = 3'd2;
  localparam [2:0] T_LEN   = 3'd3;
  localparam [2:0] T_PAY   = 3'd4;
  localparam [2:0] T_FCSL  = 3'd5;
  localparam [2:0] T_FCSH  = 3'd6;
  localparam [2:0] T_DRAIN = 3'd7;

  localparam [2:0] R_HUNT  = 3'd0;
  localparam [2:0] R_LEN   = 3'd1;
  localparam [2:0] R_PAY   = 3'd2;
  localparam [2:0] R_FCSL  = 3'd3;
  localparam [2:0] R_FCSH  = 3'd4;

  // Pin synchronisers
  reg        sclk_m;
  reg        sclk_q;
  reg        sclk_p;
  reg        cs_m;
  reg        cs_q;
  reg        mosi_m;
  reg        mosi_q;

  // Serial link state
  reg  [2:0] bit_cnt;
  reg  [6:0] byte_idx;
  reg  [7:0] in_sr;
  reg  [7:0] cmd;
  reg  [7:0] out_sr;
  reg  [7:0] out_byte;

  // Buffers
  reg [15:0] tx_mem [0:63];
  reg [15:0] rx_mem [0:63];

  // Transmit framer
  reg  [2:0] tx_state;
  reg  [6:0] tx_cnt;
  reg  [6:0] tx_len;
  reg        push_valid;
  reg  [7:0] push_data;

  // Receive parser
  reg  [2:0] rx_state;
  reg  [2:0] pre_cnt;
  reg  [6:0] rx_cnt;
  reg  [6:0] frame_length_field;
  reg  [7:0] fcs_lo;
  reg  [6:0] rx_len;
  reg        rx_crc_ok;
  reg  [7:0] rx_lqi;

  // Measurements and status
  reg        lqi_run;
  reg [15:0] lqi_cnt;
  reg  [7:0] lqi_peak;
  reg        ed_run;
  reg [15:0] ed_cnt;
  reg [23:0] ed_acc;
  reg  [7:0] ed_value;
  reg  [2:0] stat;
  reg  [2:0] next_stat;

  wire        sel       = ~cs_q;
  wire        sclk_rise = sclk_q & ~sclk_p;
  wire        sclk_fall = ~sclk_q & sclk_p;
  wire [7:0]  in_byte   = {in_sr[6:0], mosi_q};
  wire        byte_done = sel & sclk_rise & (bit_cnt == 3'd7);
  wire        first     = (byte_idx == 7'd0);
  wire [6:0]  wr_k      = byte_idx - 7'd2;
  wire [6:0]  rd_k      = byte_idx - 7'd3;
  wire [15:0] rd_word   = rx_mem[rd_k[6:1]];
  wire [15:0] tx_word   = tx_mem[tx_cnt[6:1]];
  wire [7:0]  tx_byte   = tx_cnt[0] ? tx_word[15:8] : tx_word[7:0];

  wire tx_wr_len  = byte_done & ~first & (cmd == `CMD_TX_WRITE) & (byte_idx == 7'd1);
  wire tx_wr_byte = byte_done & (cmd == `CMD_TX_WRITE) & (byte_idx >= 7'd2) & (wr_k < MAX_PAY);
  wire tx_go      = byte_done & first & (in_byte == `CMD_TX_GO);
  wire ed_go      = byte_done & first & (in_byte == `CMD_ED_GO);
  wire stat_rd    = byte_done & (cmd == `CMD_STATUS) & (byte_idx == 7'd1);

  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;
  wire        push_fire = push_valid & fifo_in_ready;
  wire        fifo_take = ~sym_valid | sym_ready;
  wire [15:0] tx_crc;
  wire [15:0] rx_crc;

  wire rx_pay_fire = rx_valid & (rx_state == R_PAY);
  wire pre_done    = rx_valid & (rx_state == R_HUNT) & (rx_data == `PRE_BYTE) &
                     (pre_cnt == PRE_LAST);
  wire rx_commit   = rx_valid & (rx_state == R_FCSH);
  wire tx_finish   = (tx_state == T_DRAIN) & ~fifo_out_valid & ~sym_valid;
  wire ed_finish   = ed_run & (ed_cnt == ED_LAST);
  // Running sum including this cycle's sample, so the result spans all ED_CYCLES samples
  wire [23:0] ed_sum = ed_acc + {16'h0000, bb_energy};

  // Two-stage capture of the host pins; sclk_p only follows the second stage
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_m <= 1'b0;
      sclk_q <= 1'b0;
      sclk_p <= 1'b0;
      cs_m   <= 1'b1;
      cs_q   <= 1'b1;
      mosi_m <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      sclk_m <= spi_sclk;
      sclk_q <= sclk_m;
      sclk_p <= sclk_q;
      cs_m   <= spi_cs_n;
      cs_q   <= cs_m;
      mosi_m <= spi_mosi;
      mosi_q <= mosi_m;
    end
  end

  // Receive shifter, byte counter and command latch; select high ends a transaction
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt  <= 3'd0;
      byte_idx <= 7'd0;
      in_sr    <= 8'h00;
      cmd      <= 8'h00;
    end else if (!sel) begin
      bit_cnt  <= 3'd0;
      byte_idx <= 7'd0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'd1;
      in_sr   <= in_byte;
      if (bit_cnt == 3'd7) begin
        if (byte_idx != 7'd127) begin
          byte_idx <= byte_idx + 7'd1;
        end
        if (first) begin
          cmd <= in_byte;
        end
      end
    end
  end

  // Answer byte chosen by command and byte position
  always @* begin
    out_byte = 8'h00;
    if (cmd == `CMD_RX_READ) begin
      if (byte_idx == 7'd1) begin
        out_byte = {rx_crc_ok, rx_len};
      end else if (byte_idx == 7'd2) begin
        out_byte = rx_lqi;
      end else if (byte_idx >= 7'd3) begin
        out_byte = rd_k[0] ? rd_word[15:8] : rd_word[7:0];
      end
    end else if (cmd == `CMD_STATUS) begin
      if (byte_idx == 7'd1) begin
        out_byte = {rx_crc_ok, 4'h0, stat};
      end else if (byte_idx == 7'd2) begin
        out_byte = ed_value;
      end
    end
  end

  // Transmit shifter, changes on falling clock edges, most significant bit first
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
      out_sr      <= 8'h00;
    end else begin
      spi_miso_oe <= sel;
      if (!sel) begin
        spi_miso <= 1'b0;
        out_sr   <= 8'h00;
      end else if (sclk_fall) begin
        if (bit_cnt == 3'd0) begin
          spi_miso <= out_byte[7];
          out_sr   <= {out_byte[6:0], 1'b0};
        end else begin
          spi_miso <= out_sr[7];
          out_sr   <= {out_sr[6:0], 1'b0};
        end
      end
    end
  end

  // Buffer writes: host fills transmit words, parser fills receive words
  always @(posedge clk) begin
    if (tx_wr_byte) begin
      if (wr_k[0]) begin
        tx_mem[wr_k[6:1]] <= {in_byte, tx_mem[wr_k[6:1]][7:0]};
      end else begin
        tx_mem[wr_k[6:1]] <= {tx_mem[wr_k[6:1]][15:8], in_byte};
      end
    end
    if (rx_pay_fire) begin
      if (rx_cnt[0]) begin
        rx_mem[rx_cnt[6:1]] <= {rx_data, rx_mem[rx_cnt[6:1]][7:0]};
      end else begin
        rx_mem[rx_cnt[6:1]] <= {rx_mem[rx_cnt[6:1]][15:8], rx_data};
      end
    end
  end

  // Byte offered to the output queue in each framer state except T_IDLE and T_DRAIN, which offer none
  always @* begin
    push_valid = 1'b1;
    push_data  = 8'h00;
    case (tx_state)
      T_PRE:   push_data = `PRE_BYTE;
      T_SFD:   push_data = `SFD_BYTE;
      T_LEN:   push_data = {1'b0, tx_len + FCS_LEN};
      T_PAY:   push_data = tx_byte;
      T_FCSL:  push_data = tx_crc[7:0];
      T_FCSH:  push_data = tx_crc[15:8];
      default: push_valid = 1'b0;
    endcase
  end

  // Transmit framer; a request while busy is ignored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= T_IDLE;
      tx_cnt   <= 7'd0;
      tx_len   <= 7'd0;
    end else begin
      if (tx_wr_len && tx_state == T_IDLE) begin
        tx_len <= (in_byte > {1'b0, MAX_PAY}) ? MAX_PAY : in_byte[6:0];
      end
      case (tx_state)
        T_IDLE: begin
          tx_cnt <= 7'd0;
          if (tx_go) begin
            tx_state <= T_PRE;
          end
        end
        T_PRE: begin
          if (push_fire) begin
            tx_cnt <= tx_cnt + 7'd1;
            if (tx_cnt[2:0] == PRE_LAST) begin
              tx_cnt   <= 7'd0;
              tx_state <= T_SFD;
            end
          end
        end
        T_SFD: begin
          if (push_fire) begin
            tx_state <= T_LEN;
          end
        end
        T_LEN: begin
          if (push_fire) begin
            tx_state <= (tx_len == 7'd0) ? T_FCSL : T_PAY;
          end
        end
        T_PAY: begin
          if (push_fire) begin
            tx_cnt <= tx_cnt + 7'd1;
            if (tx_cnt == tx_len - 7'd1) begin
              tx_state <= T_FCSL;
            end
          end
        end
        T_FCSL: begin
          if (push_fire) begin
            tx_state <= T_FCSH;
          end
        end
        T_FCSH: begin
          if (push_fire) begin
            tx_state <= T_DRAIN;
          end
        end
        default: begin
          if (tx_finish) begin
            tx_state <= T_IDLE;
          end
        end
      endcase
    end
  end

  // Check sequence over transmitted payload only
  crc16_unit u_tx_crc (
    .clk  (clk),
    .rstn (rstn),
    .clr  (tx_go & (tx_state == T_IDLE)),
    .en   (push_fire & (tx_state == T_PAY)),
    .data (tx_byte),
    .crc  (tx_crc)
  );

  // Queue between framer and modem; a full queue stalls the framer
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_tx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_out_data)
  );

  // Registered output stage toward the modem
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sym_valid <= 1'b0;
      sym_data  <= 8'h00;
    end else if (fifo_take) begin
      sym_valid <= fifo_out_valid;
      // Empty queue storage is never written, so keep the last byte instead
      if (fifo_out_valid) begin
        sym_data <= fifo_out_data;
      end
    end
  end

  // Receive parser
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state           <= R_HUNT;
      pre_cnt            <= 3'd0;
      rx_cnt             <= 7'd0;
      frame_length_field <= 7'd0;
      fcs_lo             <= 8'h00;
      rx_len             <= 7'd0;
      rx_crc_ok          <= 1'b0;
      rx_lqi             <= 8'h00;
    end else if (rx_valid) begin
      case (rx_state)
        R_HUNT: begin
          rx_cnt <= 7'd0;
          if (rx_data == `PRE_BYTE) begin
            if (pre_cnt != PRE_FULL) begin
              pre_cnt <= pre_cnt + 3'd1;
            end
          end else if (rx_data == `SFD_BYTE && pre_cnt == PRE_FULL) begin
            pre_cnt  <= 3'd0;
            rx_state <= R_LEN;
          end else begin
            pre_cnt <= 3'd0;
          end
        end
        R_LEN: begin
          frame_length_field <= rx_data[6:0];
          if (rx_data[6:0] < FCS_LEN) begin
            rx_state <= R_HUNT;
          end else if (rx_data[6:0] == FCS_LEN) begin
            rx_state <= R_FCSL;
          end else if (rx_data[6:0] > MAX_PAY + FCS_LEN) begin
            rx_state <= R_HUNT;
          end else begin
            rx_state <= R_PAY;
          end
        end
        R_PAY: begin
          rx_cnt <= rx_cnt + 7'd1;
          if (rx_cnt == frame_length_field - FCS_LEN - 7'd1) begin
            rx_state <= R_FCSL;
          end
        end
        R_FCSL: begin
          fcs_lo   <= rx_data;
          rx_state <= R_FCSH;
        end
        default: begin
          rx_len    <= frame_length_field - FCS_LEN;
          rx_crc_ok <= ({rx_data, fcs_lo} == rx_crc);
          rx_lqi    <= (lqi_run && rx_level > lqi_peak) ? rx_level : lqi_peak;
          rx_state  <= R_HUNT;
        end
      endcase
    end
  end

  // Check sequence over received payload only
  crc16_unit u_rx_crc (
    .clk  (clk),
    .rstn (rstn),
    .clr  (rx_valid & (rx_state == R_LEN)),
    .en   (rx_pay_fire),
    .data (rx_data),
    .crc  (rx_crc)
  );

  // Link quality: peak level over the window that opens after the preamble
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lqi_run  <= 1'b0;
      lqi_cnt  <= 16'h0000;
      lqi_peak <= 8'h00;
    end else if (pre_done) begin
      lqi_run  <= 1'b1;
      lqi_cnt  <= 16'h0000;
      lqi_peak <= rx_level;
    end else if (lqi_run) begin
      lqi_cnt <= lqi_cnt + 16'h0001;
      if (rx_level > lqi_peak) begin
        lqi_peak <= rx_level;
      end
      if (lqi_cnt == LQI_LAST) begin
        lqi_run <= 1'b0;
      end
    end
  end

  // Energy detect: sum of baseband energy over the integration period
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ed_run   <= 1'b0;
      ed_cnt   <= 16'h0000;
      ed_acc   <= 24'h00_0000;
      ed_value <= 8'h00;
    end else if (ed_go) begin
      ed_run <= 1'b1;
      ed_cnt <= 16'h0000;
      ed_acc <= 24'h00_0000;
    end else if (ed_run) begin
      ed_cnt <= ed_cnt + 16'h0001;
      ed_acc <= ed_sum;
      if (ed_finish) begin
        ed_run   <= 1'b0;
        ed_value <= ed_sum[23] ? 8'hFF : ed_sum[22:15];
      end
    end
  end

  // Sticky events; a status read clears them but a new event wins
  always @* begin
    next_stat = stat & {3{~stat_rd}};
    if (tx_finish) begin
      next_stat[`ST_TX_DONE] = 1'b1;
    end
    if (rx_commit) begin
      next_stat[`ST_RX_DONE] = 1'b1;
    end
    if (ed_finish) begin
      next_stat[`ST_ED_DONE] = 1'b1;
    end
  end

  // Status and the single interrupt line
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat  <= 3'b000;
      irq_n <= 1'b1;
    end else begin
      stat  <= next_stat;
      irq_n <= ~|next_stat;
    end
  end

endmodule

// file: verif/pmfb_asserts.sv
`timescale 1ns/1ps
`include "pmfb_consts.vh"

module pmfb_asserts #(
  parameter LQI_CYCLES = 16,
  parameter ED_CYCLES  = 32
) (
  // Clock and reset
  input wire       clk,
  input wire       rstn,
  // Host serial link
  input wire       spi_sclk,
  input wire       spi_cs_n,
  input wire       spi_miso,
  input wire       spi_miso_oe,
  input wire       irq_n,
  // Modem streams
  input wire [7:0] sym_data,
  input wire       sym_valid,
  input wire       sym_ready,
  input wire [7:0] rx_data,
  input wire       rx_valid
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  reg       irq_q;
  reg [7:0] tx_idx;
  reg [2:0] zeros;
  reg       sfd_seen;
  reg [7:0] rx_left;

  // Counts accepted frame bytes, restarting when the interrupt falls
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_q  <= 1'b1;
      tx_idx <= 8'h00;
    end else begin
      irq_q <= irq_n;
      if (irq_q && !irq_n)
        tx_idx <= 8'h00;
      else if (sym_valid && sym_ready && tx_idx != 8'hFF)
        tx_idx <= tx_idx + 8'h01;
    end
  end

  // Follows receive framing to find the last check byte
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zeros    <= 3'h0;
      sfd_seen <= 1'b0;
      rx_left  <= 8'h00;
    end else if (rx_valid) begin
      if (rx_left != 8'h00)
        rx_left <= rx_left - 8'h01;
      else if (sfd_seen) begin
        sfd_seen <= 1'b0;
        rx_left  <= (rx_data < 8'h02) ? 8'h00 : rx_data;
      end else if (rx_data == `PRE_BYTE)
        zeros <= (zeros == 3'h4) ? zeros : zeros + 3'h1;
      else begin
        sfd_seen <= (rx_data == `SFD_BYTE) && (zeros == 3'h4);
        zeros    <= 3'h0;
      end
    end
  end

  sequence byte_taken; sym_valid && sym_ready; endsequence
  sequence last_rx_byte; rx_valid && rx_left == 8'h01; endsequence

  AST_RESET_IDLE: assert property ($rose(rstn) |-> irq_n && !sym_valid && !spi_miso_oe)
    else $error("outputs not idle after reset");
  AST_DESELECT_QUIET: assert property (spi_cs_n [*6] |-> !spi_miso_oe && !spi_miso)
    else $error("data out driven while deselected");
  AST_MISO_HOLD: assert property ((!spi_cs_n && spi_sclk) [*5] |-> $stable(spi_miso))
    else $error("data out moved while link clock high");
  AST_SYM_HOLD: assert property (sym_valid && !sym_ready |=> sym_valid && $stable(sym_data))
    else $error("frame byte dropped before acceptance");
  AST_PREAMBLE: assert property (byte_taken ##0 tx_idx < 8'h04 |-> sym_data == `PRE_BYTE)
    else $error("preamble byte wrong");
  AST_DELIMITER: assert property (byte_taken ##0 tx_idx == 8'h04 |-> sym_data == `SFD_BYTE)
    else $error("start delimiter wrong");
  AST_LEN_FIELD: assert property (byte_taken ##0 tx_idx == 8'h05 |-> sym_data inside {[2:127]})
    else $error("length field out of range");
  AST_RX_IRQ: assert property (last_rx_byte |-> ##[1:2] !irq_n)
    else $error("no interrupt after received frame");
endmodule

bind packet_mode_frame_buffer pmfb_asserts #(.LQI_CYCLES(LQI_CYCLES), .ED_CYCLES(ED_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .irq_n(irq_n), .sym_data(sym_data), .sym_valid(sym_valid),
  .sym_ready(sym_ready), .rx_data(rx_data), .rx_valid(rx_valid));

// file: verif/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
  // Serial link driven by the host
  output reg  sclk,
  output reg  cs_n,
  output reg  mosi,
  // Answer from the device
  input  wire miso,
  input  wire miso_oe
);
  localparam real HALF = 62.5;

  // Link idles deselected with its clock still
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Selects the device half a period before the first bit
  task begin_frame;
    cs_n = 1'b0;
    #HALF;
  endtask

  // Shifts one byte each way, most significant bit first
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    for (i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #HALF;
      sclk = 1'b1;
      rx[i] = miso_oe ? miso : 1'bx;
      #HALF;
      sclk = 1'b0;
    end
  endtask

  // Deselects; the released data line shows the inverse of its last bit
  task end_frame;
    #HALF;
    cs_n = 1'b1;
    mosi = ~mosi;
    #HALF;
  endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "pmfb_consts.vh"

module testbench;
  localparam LQI_C = 16;
  localparam ED_C  = 4096;
  reg         clk;
  reg         rstn;
  wire        spi_sclk;
  wire        spi_cs_n;
  wire        spi_mosi;
  wire        spi_miso;
  wire        spi_miso_oe;
  wire        irq_n;
  wire [7:0]  sym_data;
  wire        sym_valid;
  reg         sym_ready = 1'b0;
  reg  [7:0]  rx_data;
  reg         rx_valid;
  reg  [7:0]  rx_level;
  reg  [7:0]  bb_energy;
  int         error_cnt = 0;
  int         comparisons = 0;
  int         cycles = 0;
  int         rdy_lvl = 4;
  logic [7:0] exp_q[$];
  logic [7:0] mbuf[$];
  logic [7:0] abuf[$];
  logic [7:0] pay[$];

  packet_mode_frame_buffer #(.LQI_CYCLES(LQI_C), .ED_CYCLES(ED_C)) u_dut (
    .clk(clk), .rstn(rstn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .irq_n(irq_n), .sym_data(sym_data),
    .sym_valid(sym_valid), .sym_ready(sym_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_level(rx_level), .bb_energy(bb_energy));
  spi_host_model u_host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .miso(spi_miso), .miso_oe(spi_miso_oe));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ `CRC_POLY_REFL) : (c >> 1);
    return c;
  endfunction

  // One whole link transaction of the bytes in mbuf
  task spi_txn;
    logic [7:0] r;
    abuf.delete();
    u_host.begin_frame();
    foreach (mbuf[i]) begin
      u_host.xfer(mbuf[i], r);
      abuf.push_back(r);
    end
    u_host.end_frame();
    mbuf.delete();
  endtask

  task wait_irq(input int lim);
    for (int n = 0; n < lim && irq_n !== 1'b0; n++)
      @(posedge clk);
    check({7'h00, irq_n}, 8'h00);
  endtask

  // Reads status, which also clears it and releases the interrupt
  task read_status(input logic [2:0] done);
    mbuf = {`CMD_STATUS, 8'h00, 8'h00};
    spi_txn();
    check({5'h00, abuf[1][2:0]}, {5'h00, done});
    check({7'h00, irq_n}, 8'h01);
  endtask

  // Fills the buffer, requests sending and notes the expected frame
  task tx_frame(input int n, input int lvl);
    logic [15:0] crc;
    int m;
    m = (n > `MAX_PAYLOAD) ? `MAX_PAYLOAD : n;
    crc = 16'h0000;
    mbuf = {`CMD_TX_WRITE, 8'(n)};
    repeat (`PRE_BYTES) exp_q.push_back(`PRE_BYTE);
    exp_q.push_back(`SFD_BYTE);
    exp_q.push_back(8'(m + `FCS_BYTES));
    for (int k = 0; k < n; k++) begin
      mbuf.push_back(8'($urandom));
      if (k < m) begin
        exp_q.push_back(mbuf[k + 2]);
        crc = crc_add(crc, mbuf[k + 2]);
      end
    end
    exp_q.push_back(crc[7:0]);
    exp_q.push_back(crc[15:8]);
    spi_txn();
    rdy_lvl = lvl;
    mbuf = {`CMD_TX_GO};
    spi_txn();
    if (n > 100) begin
      mbuf = {`CMD_TX_GO};
      spi_txn();
    end
    wait_irq(4000);
    check(8'(exp_q.size()), 8'h00);
    read_status(3'h1);
    rdy_lvl = 4;
  endtask

  // Feeds a frame after a broken preamble, then reads it back
  task rx_frame(input int n, input logic bad);
    logic [15:0] crc;
    logic [7:0]  pk;
    crc = 16'h0000;
    pk = 8'h20 + 8'($urandom % 192);
    mbuf = {8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, `SFD_BYTE, 8'(n + 2)};
    pay.delete();
    for (int k = 0; k < n; k++) begin
      pay.push_back(8'($urandom));
      crc = crc_add(crc, pay[k]);
    end
    mbuf = {mbuf, pay, crc[7:0] ^ {7'h00, bad}, crc[15:8]};
    foreach (mbuf[i]) begin
      if (i == mbuf.size() - 1)
        check({7'h00, irq_n}, 8'h01);
      @(posedge clk);
      rx_data  <= mbuf[i];
      rx_valid <= 1'b1;
      rx_level <= (i == 9) ? pk : 8'h10;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_level <= 8'h10;
    end
    wait_irq(8);
    mbuf = {`CMD_RX_READ, 8'h00, 8'h00, pay};
    spi_txn();
    check({7'h00, abuf[1][7]}, {7'h00, !bad});
    check(abuf[2], pk);
    foreach (pay[k]) check(abuf[k + 3], pay[k]);
    read_status(3'h2);
  endtask

  // Modem side accepts frame bytes at a varying rate
  always @(posedge clk) sym_ready <= ($urandom % 4) < rdy_lvl;

  // Compares each accepted frame byte with the oldest note
  always @(posedge clk) begin
    if (rstn && sym_valid === 1'b1 && sym_ready)
      check(sym_data, exp_q.size() ? exp_q.pop_front() : ~sym_data);
  end

  // Cuts a hung run short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      error_cnt++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_level = 8'h10;
    bb_energy = 8'h00;
    void'($urandom(32'h587a_0345));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({7'h00, irq_n}, 8'h01);
    check({7'h00, sym_valid}, 8'h00);
    check(sym_data, 8'h00);
    check({7'h00, spi_miso_oe}, 8'h00);
    tx_frame(3, 2);
    tx_frame(126, 1);
    tx_frame(1, 4);
    rx_frame(5, 1'b0);
    rx_frame(2, 1'b1);
    @(posedge clk);
    bb_energy <= 8'h80 | 8'($urandom);
    mbuf = {`CMD_ED_GO};
    spi_txn();
    wait_irq(ED_C * 8);
    read_status(3'h4);
    check(abuf[2], 8'((ED_C * bb_energy) >> 15));
    mbuf = {8'h3C, 8'h00};
    spi_txn();
    check(abuf[1], 8'h00);
    complete_run();
  end
endmodule
